/* File: hdl/crwl_pkg.sv */
// Overview of operation
// - polarity bit picks the latch-enable level that must be held during readback
// - five-bit select names the register read back; 9 and 17..23 return nothing
// - reading back register 12 shows the current select value in bits 20:16
// - while write-protect is set, writes to registers 0..30 are dropped
// - register 31 stays writable; clearing write-protect reopens registers 0..30
// - readback works whether write-protect is set or not
package crwl_pkg;
    localparam int CRWL_WORD_W = 32;
    localparam int CRWL_REG_COUNT = 32;
    localparam int CRWL_SYNC_DEPTH = 3;
    // address field of every serial word
    localparam int CRWL_ADDR_MSB = 4;
    localparam int CRWL_ADDR_LSB = 0;
    // register numbers with special meaning
    localparam logic [4:0] CRWL_OFFS_CONTROL = 5'h1F;
    localparam logic [4:0] CRWL_OFFS_CAL_TRIGGER = 5'h1E;
    localparam logic [4:0] CRWL_OFFS_SELECT_ECHO = 5'h0C;
    localparam logic [4:0] CRWL_SEL_RESERVED_SINGLE = 5'h09;
    localparam logic [4:0] CRWL_SEL_RESERVED_LO = 5'h11;
    localparam logic [4:0] CRWL_SEL_RESERVED_HI = 5'h17;
    // fields of the readback and lock control register
    localparam int CRWL_POL_BIT = 21;
    localparam int CRWL_SEL_MSB = 20;
    localparam int CRWL_SEL_LSB = 16;
    localparam int CRWL_WP_BIT = 5;
    localparam logic [31:0] CRWL_CTRL_READ_MASK = 32'h0000003F;
    localparam logic [31:0] CRWL_REG_RESET = 32'h00000000;

    typedef logic [CRWL_REG_COUNT-1:0][CRWL_WORD_W-1:0] crwl_bank_t;
endpackage

/* File: hdl/crwl_frame_if.sv */
`timescale 1ns/1ns
// carries assembled serial words and shift events from the front end to the core
interface crwl_frame_if;
    logic word_valid;
    logic [31:0] word;
    logic shift_pulse;
    logic latch_level;

    modport front (
        output word_valid,
        output word,
        output shift_pulse,
        output latch_level
    );
    modport core (
        input word_valid,
        input word,
        input shift_pulse,
        input latch_level
    );
endinterface

/* File: hdl/crwl_serial_front.sv */
`timescale 1ns/1ns
module crwl_serial_front
    import crwl_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // serial pins
    input wire logic serial_clock_pin,
    input wire logic serial_data_pin,
    input wire logic serial_latch_enable_pin,
    // towards the core
    crwl_frame_if.front frm
);
    typedef struct packed {
        logic [CRWL_SYNC_DEPTH-1:0] clk_sync;
        logic [CRWL_SYNC_DEPTH-1:0] dat_sync;
        logic [CRWL_SYNC_DEPTH-1:0] le_sync;
        logic clk_f;
        logic dat_f;
        logic le_f;
        logic [CRWL_WORD_W-1:0] shift;
        logic word_valid;
        logic shift_pulse;
    } crwl_front_state_t;

    crwl_front_state_t front_reg;
    crwl_front_state_t front_next;

    // stage 0 feeds only stage 1; a level counts once stages 1 and 2 agree
    always_comb begin
        front_next = front_reg;
        front_next.word_valid = 1'b0;
        front_next.shift_pulse = 1'b0;
        front_next.clk_sync = {front_reg.clk_sync[1:0], serial_clock_pin};
        front_next.dat_sync = {front_reg.dat_sync[1:0], serial_data_pin};
        front_next.le_sync = {front_reg.le_sync[1:0], serial_latch_enable_pin};
        if (front_reg.clk_sync[1] == front_reg.clk_sync[2]) begin
            front_next.clk_f = front_reg.clk_sync[2];
        end
        if (front_reg.dat_sync[1] == front_reg.dat_sync[2]) begin
            front_next.dat_f = front_reg.dat_sync[2];
        end
        if (front_reg.le_sync[1] == front_reg.le_sync[2]) begin
            front_next.le_f = front_reg.le_sync[2];
        end
        // rising serial clock: shift data in msb first
        if (front_next.clk_f && !front_reg.clk_f) begin
            front_next.shift = {front_reg.shift[CRWL_WORD_W-2:0], front_reg.dat_f};
            front_next.shift_pulse = 1'b1;
        end
        // rising latch enable ends a word; host must not clock on the same edge
        if (front_next.le_f && !front_reg.le_f) begin
            front_next.word_valid = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            front_reg <= '0;
        end else begin
            front_reg <= front_next;
        end
    end

    assign frm.word_valid = front_reg.word_valid;
    assign frm.word = front_reg.shift;
    assign frm.shift_pulse = front_reg.shift_pulse;
    assign frm.latch_level = front_reg.le_f;
endmodule

/* File: hdl/crwl_readback_lock.sv */
`timescale 1ns/1ns
module crwl_readback_lock
    import crwl_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // three-wire serial configuration pins
    input wire logic serial_clock_pin,
    input wire logic serial_data_pin,
    input wire logic serial_latch_enable_pin,
    // readback data pin
    output logic readback_data_pin,
    // status and side effects
    output logic cal_sync_start,
    output logic config_write_protect,
    output logic readback_latch_polarity
);
    typedef struct packed {
        crwl_bank_t bank;
        logic [CRWL_WORD_W-1:0] rb_shift;
        logic rb_out;
        logic cal_start;
    } crwl_core_state_t;

    crwl_core_state_t core_reg;
    crwl_core_state_t core_next;

    crwl_frame_if frm ();

    // pin sampling and word assembly
    crwl_serial_front u_front (
        .mclk(mclk),
        .reset_n(reset_n),
        .serial_clock_pin(serial_clock_pin),
        .serial_data_pin(serial_data_pin),
        .serial_latch_enable_pin(serial_latch_enable_pin),
        .frm(frm)
    );

    // select values with no register behind them
    function automatic logic sel_reserved(input logic [4:0] sel);
        sel_reserved = (sel == CRWL_SEL_RESERVED_SINGLE) ||
            ((sel >= CRWL_SEL_RESERVED_LO) && (sel <= CRWL_SEL_RESERVED_HI));
    endfunction

    // word presented for readback of the selected register
    function automatic logic [CRWL_WORD_W-1:0] readback_word(input crwl_bank_t bank, input logic [4:0] sel);
        logic [CRWL_WORD_W-1:0] w;
        w = bank[sel];
        if (sel_reserved(sel)) begin
            w = '0;
        end else if (sel == CRWL_OFFS_SELECT_ECHO) begin
            w[CRWL_SEL_MSB:CRWL_SEL_LSB] = sel;
        end else if (sel == CRWL_OFFS_CONTROL) begin
            w = w & CRWL_CTRL_READ_MASK; // only bits 5:0 read back; the select and polarity bits read as zero
        end
        readback_word = w;
    endfunction

    logic [4:0] wr_addr;
    logic wr_allowed;

    // address decode and lock gate of an incoming word
    always_comb begin
        wr_addr = frm.word[CRWL_ADDR_MSB:CRWL_ADDR_LSB];
        // control register bypasses the lock so it can always be cleared
        wr_allowed = (wr_addr == CRWL_OFFS_CONTROL) ||
            !core_reg.bank[CRWL_OFFS_CONTROL][CRWL_WP_BIT];
    end

    // register writes, calibration trigger and readback shifter
    always_comb begin
        core_next = core_reg;
        core_next.cal_start = 1'b0;
        if (frm.word_valid && wr_allowed) begin
            core_next.bank[wr_addr] = frm.word;
            // only an accepted write to the trigger register starts calibration
            if (wr_addr == CRWL_OFFS_CAL_TRIGGER) begin
                core_next.cal_start = 1'b1;
            end
        end
        // readback loads on every control write, locked or not
        if (frm.word_valid && (wr_addr == CRWL_OFFS_CONTROL)) begin
            core_next.rb_shift = readback_word(core_reg.bank,
                frm.word[CRWL_SEL_MSB:CRWL_SEL_LSB]);
        end else if (frm.shift_pulse &&
            (frm.latch_level == core_reg.bank[CRWL_OFFS_CONTROL][CRWL_POL_BIT])) begin
            // bits leave only while latch enable sits at the chosen level
            core_next.rb_shift = {core_reg.rb_shift[CRWL_WORD_W-2:0], 1'b0};
        end
        core_next.rb_out = core_next.rb_shift[CRWL_WORD_W-1];
    end

    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            core_reg <= '0;
        end else begin
            core_reg <= core_next;
        end
    end

    // outputs straight from flip-flops
    assign readback_data_pin = core_reg.rb_out;
    assign cal_sync_start = core_reg.cal_start;
    assign config_write_protect = core_reg.bank[CRWL_OFFS_CONTROL][CRWL_WP_BIT];
    assign readback_latch_polarity = core_reg.bank[CRWL_OFFS_CONTROL][CRWL_POL_BIT];
endmodule

/* File: tb/crwl_readback_lock_assertions.sv */
`timescale 1ns/1ns
module crwl_readback_lock_checker
    import crwl_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // serial pins and outputs
    input wire logic serial_clock_pin,
    input wire logic serial_data_pin,
    input wire logic serial_latch_enable_pin,
    input wire logic readback_data_pin,
    input wire logic cal_sync_start,
    input wire logic config_write_protect,
    input wire logic readback_latch_polarity
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic le_q, sc_q;
    logic [3:0] le_age, sc_age;
    // cycles since a pin rose; saturates so long idle stretches never wrap
    always_ff @(posedge mclk) begin
        le_q <= serial_latch_enable_pin;
        sc_q <= serial_clock_pin;
        le_age <= (!reset_n) ? 4'hF : (serial_latch_enable_pin && !le_q) ? 4'h0 : le_age + {3'h0, le_age != 4'hF};
        sc_age <= (!reset_n) ? 4'hF : (serial_clock_pin && !sc_q) ? 4'h0 : sc_age + {3'h0, sc_age != 4'hF};
    end
    a_cal_single_pulse: assert property (cal_sync_start |=> !cal_sync_start) else $error("cal pulse too long");
    a_cal_when_open: assert property (cal_sync_start |-> !config_write_protect) else $error("cal while locked");
    a_cal_after_latch: assert property (cal_sync_start |-> le_age inside {[3:9]}) else $error("cal without latch");
    a_wp_after_latch: assert property ($changed(config_write_protect) |-> le_age inside {[3:9]})
        else $error("lock moved without latch");
    a_pol_after_latch: assert property ($changed(readback_latch_polarity) |-> le_age inside {[3:9]})
        else $error("polarity moved without latch");
    a_wp_holds_after: assert property (
        $changed(config_write_protect) |=> $stable(config_write_protect) [*7])
        else $error("lock bounced");
    a_rb_pin_cause: assert property ($changed(readback_data_pin) |-> sc_age <= 4'h9 || le_age <= 4'h9)
        else $error("readback moved idle");
    a_reset_unlocked: assert property ($rose(reset_n) |-> !config_write_protect && !readback_latch_polarity)
        else $error("not clear after reset");
    c_cal: cover property (cal_sync_start);
    c_lock: cover property ($rose(config_write_protect));
    c_unlock: cover property ($fell(config_write_protect));
endmodule
bind crwl_readback_lock crwl_readback_lock_checker u_chk (.mclk(mclk), .reset_n(reset_n),
    .serial_clock_pin(serial_clock_pin), .serial_data_pin(serial_data_pin),
    .serial_latch_enable_pin(serial_latch_enable_pin), .readback_data_pin(readback_data_pin),
    .cal_sync_start(cal_sync_start), .config_write_protect(config_write_protect),
    .readback_latch_polarity(readback_latch_polarity));

/* File: tb/crwl_host_model.sv */
`timescale 1ns/1ns
module crwl_host_model (
    // clock
    input wire logic mclk,
    // serial pins and readback
    output logic serial_clock_pin,
    output logic serial_data_pin,
    output logic serial_latch_enable_pin,
    input wire logic readback_data_pin
);
    // serial clock stands low outside frames
    initial begin
        serial_clock_pin = 1'b0;
        serial_data_pin = 1'b0;
        serial_latch_enable_pin = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // msb first; five cycles a phase clears the three-flop synchronisers
    task automatic send(input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            serial_data_pin = w[i];
            tick(5);
            serial_clock_pin = 1'b1;
            tick(5);
            serial_clock_pin = 1'b0;
        end
        serial_latch_enable_pin = 1'b1;
        tick(5);
        serial_latch_enable_pin = 1'b0;
        serial_data_pin = ~serial_data_pin; // released line must not keep a stale level
        tick(8);
    endtask
    // latch enable held at the programmed level while bits are clocked out
    task automatic fetch(input logic pol, output logic [31:0] rb);
        serial_latch_enable_pin = pol;
        tick(8);
        for (int i = 31; i >= 0; i--) begin
            rb[i] = readback_data_pin;
            serial_clock_pin = 1'b1;
            tick(5);
            serial_clock_pin = 1'b0;
            tick(5);
        end
        serial_latch_enable_pin = 1'b0;
        tick(5);
    endtask
endmodule

/* File: tb/tb_crwl_readback_lock.sv */
`timescale 1ns/1ns
module tb_crwl_readback_lock;
    import crwl_pkg::*;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    // nets driven by the host model and the design
    wire logic sck, sdi, sle, rb_pin, cal, wp, pol;
    int fail_count = 0;
    int n_compared = 0;
    int n_cal = 0;
    logic [31:0] rb;
    logic [4:0] rsv [3] = '{5'h09, 5'h11, 5'h17};
    always #5 mclk = ~mclk;
    // count calibration pulses so blocked writes can be proven silent
    always @(posedge mclk) if (cal === 1'b1) n_cal++;
    crwl_readback_lock DUT (.mclk(mclk), .reset_n(reset_n), .serial_clock_pin(sck), .serial_data_pin(sdi),
        .serial_latch_enable_pin(sle), .readback_data_pin(rb_pin), .cal_sync_start(cal),
        .config_write_protect(wp), .readback_latch_polarity(pol));
    crwl_host_model host (.mclk(mclk), .serial_clock_pin(sck), .serial_data_pin(sdi),
        .serial_latch_enable_pin(sle), .readback_data_pin(rb_pin));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic final_report();
        if (fail_count == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    // control word: polarity, select, write-protect, address 31
    function automatic logic [31:0] ctl(input logic p, input logic [4:0] s, input logic w);
        ctl = 32'h0000001F;
        ctl[CRWL_POL_BIT] = p;
        ctl[CRWL_SEL_MSB:CRWL_SEL_LSB] = s;
        ctl[CRWL_WP_BIT] = w;
    endfunction
    task automatic t_plain();
        host.send(32'hA5C3F005);
        host.send(ctl(1'b0, 5'h05, 1'b0));
        host.fetch(1'b0, rb);
        check("r5", rb, 32'hA5C3F005);
        host.send(32'hFFFFFFEC);
        host.send(ctl(1'b0, 5'h0C, 1'b0));
        host.fetch(1'b0, rb);
        check("r12", rb, 32'hFFECFFEC);
    endtask
    // reserved selects: the single one and both ends of the range
    task automatic t_reserved();
        foreach (rsv[k]) begin
            host.send({27'h7FFFFFF, rsv[k]});
            host.send(ctl(1'b0, rsv[k], 1'b0));
            host.fetch(1'b0, rb);
            check("rsv", rb, 32'h00000000);
        end
    endtask
    task automatic t_lock();
        host.send(ctl(1'b1, 5'h05, 1'b1));
        check("wp pol", {30'h0, wp, pol}, 32'h00000003);
        n_cal = 0;
        host.send(32'h12345665);
        host.send(32'h0000001E);
        check("cal", n_cal, 0);
        host.fetch(1'b1, rb);
        check("locked r5", rb, 32'hA5C3F005);
        host.send(ctl(1'b1, 5'h1F, 1'b1));
        host.fetch(1'b1, rb);
        check("r31", rb & 32'h0000003F, 32'h0000003F);
        host.send(ctl(1'b0, 5'h05, 1'b0));
        host.send(32'h0000001E);
        check("unlock cal", {30'h0, wp, n_cal == 1}, 32'h00000001);
        host.send(32'h12345665);
        host.send(ctl(1'b0, 5'h05, 1'b0));
        host.fetch(1'b0, rb);
        check("r5 new", rb, 32'h12345665);
    endtask
    // reset in mid-run drops the lock, the polarity and every stored word
    task automatic t_reset();
        host.send(ctl(1'b1, 5'h05, 1'b1));
        reset_n = 1'b0;
        host.tick(2);
        reset_n = 1'b1;
        host.tick(4);
        check("rst wp pol", {30'h0, wp, pol}, 32'h00000000);
        host.send(ctl(1'b0, 5'h05, 1'b0));
        host.fetch(1'b0, rb);
        check("rst r5", rb, 32'h00000000);
    endtask
    // a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge mclk);
        fail_count++;
        final_report();
    end
    initial begin
        repeat (16) @(posedge mclk);
        #1;
        reset_n = 1'b1;
        host.tick(4);
        check("reset", {30'h0, wp, pol}, 32'h00000000);
        t_plain();
        t_reserved();
        t_lock();
        t_reset();
        final_report();
    end
endmodule
